// >>> inc/irq_pins_defs.vh
// Register map, field layout, reset values and timing for the interrupt pin block
`ifndef IRQ_PINS_DEFS_VH
`define IRQ_PINS_DEFS_VH

// Register byte offsets
`define OFS_POLARITY 8'h00
`define OFS_STATUS 8'h04
`define OFS_CLEAR 8'h08
`define OFS_ENABLE 8'h0c
`define OFS_SERVICE 8'h10
`define OFS_ACK_STATE 8'h14

// Status, clear and enable layout
`define STAT_NMI_BIT 0
`define STAT_EXT_LSB 4
`define STAT_MASK 8'hf1

// Service command layout
`define SVC_NUM_LSB 0
`define SVC_NUM_MSB 3

// Ack state layout
`define ACKST_BUSY_BIT 4

// Reset values
`define POLARITY_RST 4'h0
`define ENABLE_RST 8'h00
`define STATUS_RST 8'h00
`define NUM_RST 4'h0

// Service slot codes of the pin sources
`define SLOT_NMI 4'h1
`define SLOT_EXT4 4'h4

// Acknowledge pulse time and clock period in nanoseconds
`define ACK_TIME_NS 8
`define CLK_PERIOD_NS 4

`endif

// >>> verilog/pin_sync.v
// Two-flop synchroniser bank for asynchronous interrupt pins
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 5
) (
	input wire pclk,
	input wire presetn,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	// First stage, read only by the second stage
	reg [WIDTH-1:0] meta_reg;
	// Second stage, safe for logic
	reg [WIDTH-1:0] stable_reg;

	// Both stages clear to low so no false edge is seen after reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= {WIDTH{1'b0}};
			stable_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_in;
			stable_reg <= meta_reg;
		end
	end

	assign sync_out = stable_reg;

endmodule

// >>> verilog/irq_pin_signalling.v
// Interrupt pin front end: edge detection, sticky status and service acknowledge
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "irq_pins_defs.vh"
module irq_pin_signalling (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire nmi_line,
	input wire ext_irq_line_4,
	input wire ext_irq_line_5,
	input wire ext_irq_line_6,
	input wire ext_irq_line_7,
	output reg irq_out,
	output reg irq_service_ack,
	output reg [3:0] serviced_irq_number
);

	// Acknowledge length in cycles, least time rounded up, at least one
	// The counter is four bits wide, so lengths above sixteen cycles wrap around
	localparam integer ACK_CYC_RAW = (`ACK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam integer ACK_CYCLES = (ACK_CYC_RAW < 1) ? 1 : ACK_CYC_RAW;
	localparam [3:0] ACK_LOAD = ACK_CYCLES[3:0];

	// Acknowledge sequencer states, one-hot
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_ACK = 2'b10;

	// Pin bundle: bit 0 is the nonmaskable line, bits 1..4 external 4..7
	wire [4:0] pin_raw;
	// Synchronised pin levels
	wire [4:0] pin_sync_lvl;
	// Previous active level per pin, for edge detection
	reg [4:0] prev_reg;
	// Active level after polarity correction
	wire [4:0] active_lvl;
	// One-cycle event per pin
	wire [4:0] event_hit;
	// Events placed in status layout
	reg [7:0] event_vec;

	// Polarity select bits for the external lines
	reg [3:0] ext_irq_polarity_bits_reg;
	// Sticky event status
	reg [7:0] status_reg;
	// Status after clear and new events of this cycle
	reg [7:0] status_next;
	// Interrupt enable mask
	reg [7:0] enable_reg;
	// Enable mask after a write of this cycle
	reg [7:0] enable_next;
	// Acknowledge sequencer
	reg [1:0] state_reg;
	reg [1:0] state_next;
	// Acknowledge cycles still to run
	reg [3:0] ack_cnt_reg;
	reg [3:0] ack_cnt_next;
	// Number and acknowledge for the next cycle
	reg [3:0] num_next;
	reg ack_next;

	// Bus decode helpers
	wire setup_phase;
	wire access_done;
	wire wr_done;
	// Address matches a mapped register
	reg addr_hit;
	// Read word selected by the address
	reg [31:0] rd_mux;

	// Gather the pins so one synchroniser bank serves them all
	assign pin_raw = {ext_irq_line_7, ext_irq_line_6, ext_irq_line_5,
		ext_irq_line_4, nmi_line};

	// Two flops per pin; events therefore lag the pins by two cycles
	// Pin synchronisers
	pin_sync #(
		.WIDTH(5)
	) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pin_raw),
		.sync_out(pin_sync_lvl)
	);

	// Polarity correction and edge detection
	// The nonmaskable line has no polarity bit, so only a rising pin counts
	// NMI rising edge
	assign active_lvl[0] = pin_sync_lvl[0];
	assign event_hit[0] = active_lvl[0] & ~prev_reg[0];

	// One identical detector per external line
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_ext
			// Polarity bit high means the line is active low, so a falling
			// pin edge becomes a rising active level
			// Per-line polarity select
			assign active_lvl[gi+1] = pin_sync_lvl[gi+1] ^ ext_irq_polarity_bits_reg[gi];
			assign event_hit[gi+1] = active_lvl[gi+1] & ~prev_reg[gi+1];
		end
	endgenerate

	// Events mapped onto the status layout
	// Bits 3:1 of the layout are unused and stay zero
	always @* begin
		event_vec = 8'h00;
		event_vec[`STAT_NMI_BIT] = event_hit[0];
		event_vec[`STAT_EXT_LSB+3:`STAT_EXT_LSB] = event_hit[4:1];
	end

	// Previous level tracker; a steady level yields no new event
	// It follows the corrected level, so a polarity write can look like an edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= 5'h00;
		end else begin
			prev_reg <= active_lvl;
		end
	end

	// APB phase decode
	// Zero wait states: every access cycle is also the completing one
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_done = access_done & pwrite & ~pslverr;

	// Address decode and read data selection
	// Misaligned and unknown offsets fall to the default and answer with an error
	always @* begin
		addr_hit = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			`OFS_POLARITY: begin
				rd_mux[3:0] = ext_irq_polarity_bits_reg;
			end
			`OFS_STATUS: begin
				rd_mux[7:0] = status_reg;
			end
			`OFS_CLEAR: begin
				// Write-only, reads as zero
				rd_mux = 32'h00000000;
			end
			`OFS_ENABLE: begin
				rd_mux[7:0] = enable_reg;
			end
			`OFS_SERVICE: begin
				// Write-only command, reads as zero
				rd_mux = 32'h00000000;
			end
			`OFS_ACK_STATE: begin
				// Busy flag and the number being presented
				rd_mux[`ACKST_BUSY_BIT] = irq_service_ack;
				rd_mux[3:0] = serviced_irq_number;
			end
			default: begin
				// Unmapped offset, refused with an error
				addr_hit = 1'b0;
			end
		endcase
	end

	// Bus answer registers: ready and data are set up during the setup cycle,
	// so every transfer finishes in its first access cycle
	// Writes return zero data; only reads carry the decoded word
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (setup_phase) begin
			pready <= 1'b1;
			pslverr <= ~addr_hit;
			prdata <= pwrite ? 32'h00000000 : rd_mux;
		end else begin
			// Drop ready after the access so a stale answer never lingers
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Next enable mask; the interrupt output reads it so that a mask write
	// reaches the pin at the same edge as the register
	always @* begin
		enable_next = enable_reg;
		if (wr_done && (paddr == `OFS_ENABLE)) begin
			// Unused layout bits are forced to zero
			enable_next = pwdata[7:0] & `STAT_MASK;
		end
	end

	// Polarity and enable registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_irq_polarity_bits_reg <= `POLARITY_RST;
			enable_reg <= `ENABLE_RST;
		end else begin
			enable_reg <= enable_next;
			if (wr_done && (paddr == `OFS_POLARITY)) begin
				// Changing polarity can itself produce one edge event
				ext_irq_polarity_bits_reg <= pwdata[3:0];
			end
		end
	end

	// Sticky status: a new event wins over a clear in the same cycle
	// Software clearing a bit therefore never loses an event it has not seen
	always @* begin
		status_next = status_reg;
		if (wr_done && (paddr == `OFS_CLEAR)) begin
			status_next = status_next & ~pwdata[7:0];
		end
		status_next = (status_next | event_vec) & `STAT_MASK;
	end

	// Events last one cycle; only this sticky word remembers them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= `STATUS_RST;
		end else begin
			status_reg <= status_next;
		end
	end

	// Level interrupt from enabled status bits
	// Built from next values so it moves at the same edge as status and mask
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(status_next & enable_next);
		end
	end

	// Acknowledge sequencer: a service write starts it; a write while
	// busy is ignored so the presented number never changes mid-pulse
	// Software may poll the ack state register before the next command
	always @* begin
		state_next = state_reg;
		ack_cnt_next = ack_cnt_reg;
		ack_next = irq_service_ack;
		num_next = serviced_irq_number;
		case (state_reg)
			ST_IDLE: begin
				ack_next = 1'b0;
				if (wr_done && (paddr == `OFS_SERVICE)) begin
					state_next = ST_ACK;
					ack_cnt_next = ACK_LOAD;
					ack_next = 1'b1;
					num_next = pwdata[`SVC_NUM_MSB:`SVC_NUM_LSB];
				end
			end
			ST_ACK: begin
				// Count down; the last count ends the pulse
				// Number held during ack
				if (ack_cnt_reg == 4'h1) begin
					state_next = ST_IDLE;
					ack_cnt_next = 4'h0;
					ack_next = 1'b0;
				end else begin
					ack_cnt_next = ack_cnt_reg - 4'h1;
				end
			end
			default: begin
				// Illegal state recovers to idle with acknowledge low
				state_next = ST_IDLE;
				ack_cnt_next = 4'h0;
				ack_next = 1'b0;
			end
		endcase
	end

	// Sequencer registers; the number keeps its last value after the pulse
	// so system logic may still read it once acknowledge has fallen
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			ack_cnt_reg <= 4'h0;
			irq_service_ack <= 1'b0;
			serviced_irq_number <= `NUM_RST;
		end else begin
			state_reg <= state_next;
			ack_cnt_reg <= ack_cnt_next;
			irq_service_ack <= ack_next;
			serviced_irq_number <= num_next;
		end
	end

endmodule

// >>> test/irq_pin_checker.sv
// Port assertions for the interrupt pin block
`timescale 1ns/1ps
module irq_pin_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire nmi_line,
	input wire ext_irq_line_4,
	input wire ext_irq_line_5,
	input wire ext_irq_line_6,
	input wire ext_irq_line_7,
	input wire irq_out,
	input wire irq_service_ack,
	input wire [3:0] serviced_irq_number
);
	// Pin bank and write strobes
	wire [4:0] pins = {nmi_line, ext_irq_line_7, ext_irq_line_6, ext_irq_line_5, ext_irq_line_4};
	wire wr = psel && penable && pwrite;
	wire svc_wr = wr && paddr == 8'h10;
	reg [4:0] pins_d;
	// Saturating count of quiet cycles; a raised irq needs a recent cause
	reg [2:0] quiet_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_d <= 5'h00;
			quiet_reg <= 3'h0;
		end else begin
			pins_d <= pins;
			quiet_reg <= (pins != pins_d || (psel && pwrite)) ? 3'h0 :
				quiet_reg + {2'h0, quiet_reg != 3'h7};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_access: assert property (psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	chk_err_unmapped: assert property (pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_ack_start: assert property (svc_wr && !irq_service_ack |=>
		irq_service_ack && {28'h0, serviced_irq_number} == ($past(pwdata) & 32'hf))
		else $error("service write gave wrong ack or number");
	chk_ack_len: assert property ($rose(irq_service_ack) |=> irq_service_ack ##1 !irq_service_ack)
		else $error("ack pulse not two cycles");
	chk_ack_cause: assert property ($rose(irq_service_ack) |-> $past(svc_wr))
		else $error("ack without service write");
	chk_num_change: assert property ($changed(serviced_irq_number) |-> $rose(irq_service_ack))
		else $error("number moved outside ack start");
	chk_irq_cause: assert property ($rose(irq_out) |-> quiet_reg != 3'h7)
		else $error("irq raised without pin change");
	chk_irq_fall: assert property ($fell(irq_out) |-> $past(wr))
		else $error("irq dropped without write");
endmodule
bind irq_pin_signalling irq_pin_checker chk (.*);

// >>> test/irq_source.sv
// Far-side interrupt source model
`timescale 1ns/1ps
module irq_source (
	input wire pclk,
	input wire [4:0] flip,
	output reg [4:0] pins
);
	initial pins = 5'h00;
	// Each flip bit makes one edge on its pin; levels otherwise hold
	always @(posedge pclk) begin
		pins <= pins ^ flip;
	end
endmodule

// >>> test/tb_interrupt_pin_signalling.sv
// Self-checking bench for the interrupt pin block
`timescale 1ns/1ps
module tb_interrupt_pin_signalling;
	reg pclk, presetn, psel, penable, pwrite, held, e;
	reg [7:0] paddr;
	reg [31:0] pwdata, rd;
	reg [4:0] flip;
	reg [3:0] pol;
	wire [31:0] prdata;
	wire pready, pslverr, irq_out, ack;
	wire [3:0] num;
	wire [4:0] pins;
	integer bad_count, num_checks, seed, i, j;
	irq_source src (.pclk(pclk), .flip(flip), .pins(pins));
	irq_pin_signalling dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nmi_line(pins[4]), .ext_irq_line_4(pins[0]),
		.ext_irq_line_5(pins[1]), .ext_irq_line_6(pins[2]), .ext_irq_line_7(pins[3]),
		.irq_out(irq_out), .irq_service_ack(ack), .serviced_irq_number(num));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task cmp(input [31:0] got, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("MISMATCH %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// APB transfer; keep leaves psel up so the next setup follows at once
	task apb(input w, input [7:0] a, input [31:0] d, input keep);
		begin
			if (!held) @(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			rd = prdata;
			e = pslverr;
			held = keep;
			if (!keep) begin
				psel <= 1'b0;
				penable <= 1'b0;
			end
		end
	endtask
	task rdchk(input [7:0] a, input [31:0] exp);
		begin
			apb(1'b0, a, 32'h0, 1'b0);
			cmp(rd, exp);
		end
	endtask
	// One edge on the selected pins, then time for sync and status
	task pin(input [4:0] f);
		begin
			flip <= f;
			@(posedge pclk);
			flip <= 5'h00;
			repeat (6) @(posedge pclk);
		end
	endtask
	// Expected status word for one external line edge
	function [31:0] hit(input lvl, input p, input integer n);
		hit = {31'h0, lvl ^ p} << (4 + n);
	endfunction
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", num_checks, bad_count);
			if (bad_count == 0 && num_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// Watchdog far beyond the expected run of about three hundred cycles
	initial begin
		#40000;
		bad_count = bad_count + 1;
		finish_test;
	end
	initial begin
		seed = 42;
		{bad_count, num_checks, held, e} = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata, flip} = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(8'h00, 32'h0);
		rdchk(8'h04, 32'h0);
		rdchk(8'h20, 32'h0);
		cmp(e, 1'b1);
		apb(1'b1, 8'h0c, 32'hffffffff, 1'b0);
		rdchk(8'h0c, 32'hf1);
		pin(5'h10);
		rdchk(8'h04, 32'h01);
		cmp(irq_out, 1'b1);
		apb(1'b1, 8'h0c, 32'h0, 1'b0);
		#1 cmp(irq_out, 1'b0);
		apb(1'b1, 8'h08, 32'h1, 1'b0);
		apb(1'b1, 8'h0c, 32'hf1, 1'b0);
		pin(5'h00);
		rdchk(8'h04, 32'h0);
		pin(5'h10);
		rdchk(8'h04, 32'h0);
		for (i = 0; i < 4; i = i + 1) begin
			pol = $random(seed);
			apb(1'b1, 8'h00, {28'h0, pol}, 1'b0);
			pin(5'h00);
			apb(1'b1, 8'h08, 32'hf1, 1'b0);
			for (j = 0; j < 2; j = j + 1) begin
				pin(5'h01 << i);
				rdchk(8'h04, hit(pins[i], pol[i], i));
				apb(1'b1, 8'h08, 32'hf1, 1'b0);
			end
		end
		for (i = 0; i < 16; i = i + 1) begin
			apb(1'b1, 8'h10, i, 1'b0);
			#1 cmp(ack, 1'b1);
			cmp(num, i);
		end
		j = $random(seed) & 15;
		apb(1'b1, 8'h10, j, 1'b1);
		apb(1'b1, 8'h10, ~j, 1'b0);
		#1 cmp(num, j);
		rdchk(8'h14, j);
		// Read back while the pulse runs: busy flag together with the number
		apb(1'b1, 8'h10, 32'h7, 1'b1);
		rdchk(8'h14, 32'h17);
		finish_test;
	end
endmodule
